// File: cmp_out_path.sv
`timescale 1ns/10ps
// registered comparator result path with optional inversion
module cmp_out_path (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // analog side
  input  wire logic raw_in,
  input  wire logic invert,
  // result
  output logic      result
);
  typedef struct packed {
    logic result;
  } path_state_t;

  path_state_t state;
  path_state_t next_state;

  always_comb begin
    next_state        = state;
    next_state.result = raw_in ^ invert;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign result = state.result;
endmodule

// File: cmpref_pkg.sv
package cmpref_pkg;
  // register byte addresses on the bus
  localparam logic [11:0] ADDR_COMPARATOR_CONTROL        = 12'h000;
  localparam logic [11:0] ADDR_VOLTAGE_REFERENCE_CONTROL = 12'h004;
  localparam logic [11:0] ADDR_CMP_RESULT                = 12'h008;

  // comparator_control fields
  localparam int CC_CMP1_POS = 0;
  localparam int CC_CMP1_NEG = 1;
  localparam int CC_CMP2_POS = 2;
  localparam int CC_CMP2_NEG = 3;
  localparam int CC_CMP1_INV = 4;
  localparam int CC_CMP2_INV = 5;
  localparam logic [15:0] CC_WRITE_MASK = 16'h003F;
  localparam logic [15:0] CC_RESET      = 16'h0000;

  // voltage_reference_control fields
  localparam int VR_LEVEL_LSB = 0;
  localparam int VR_LEVEL_W   = 4;
  localparam int VR_SOURCE    = 4;
  localparam int VR_RANGE     = 5;
  localparam int VR_PIN_OE    = 6;
  localparam int VR_POWER     = 7;
  localparam logic [15:0] VR_WRITE_MASK = 16'h00FF;
  localparam logic [15:0] VR_RESET      = 16'h0000;

  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
endpackage

// File: comparator_reference_control.sv
`timescale 1ns/10ps
// Operation
// - bit five inverts comparator two output
// - bit four inverts comparator one output
// - bit three picks comparator two negative
// - bit two picks comparator two positive
// - bit one picks comparator one negative
// - bit zero picks comparator one positive
// - reference bit five selects ladder range
// - reference bit four selects supply source
// - four level bits drive ladder tap
module comparator_reference_control
  import cmpref_pkg::*;
(
  // apb clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // raw comparator results from the analog
  input  wire logic        cmp1_raw,
  input  wire logic        cmp2_raw,
  // comparator input muxes
  output logic             cmp1_positive_select,
  output logic             cmp1_negative_select,
  output logic             cmp2_positive_select,
  output logic             cmp2_negative_select,
  // comparator results after inversion
  output logic             cmp1_result,
  output logic             cmp2_result,
  // reference control
  output logic             ref_power_enable,
  output logic             ref_pin_output_enable,
  output logic             ref_range_select,
  output logic             ref_source_select,
  output logic [3:0]       ref_level_code
);
  import cmpref_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0] comparator_control;
    logic [15:0] voltage_reference_control;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } regs_state_t;

  regs_state_t state;
  regs_state_t next_state;
  logic        cmp1_inv_q;
  logic        cmp2_inv_q;
  logic [3:0]  ladder_tap;
  logic        ladder_range;

  // ************************************************************
  // apb decode
  // ************************************************************
  logic        access;
  logic [15:0] wmask;

  always_comb begin
    access = psel && penable && !state.pready;
    wmask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    next_state         = state;
    next_state.pready  = 1'b0;
    next_state.pslverr = 1'b0;
    next_state.prdata  = RDATA_ZERO;
    if (access) begin
      // one wait state: answer on the edge after the first access cycle
      next_state.pready = 1'b1;
      if (paddr == ADDR_COMPARATOR_CONTROL) begin
        if (pwrite) begin
          next_state.comparator_control = (state.comparator_control & ~(wmask & CC_WRITE_MASK))
                                        | (pwdata[15:0] & wmask & CC_WRITE_MASK);
        end else begin
          next_state.prdata = {16'h0000, state.comparator_control};
        end
      end else if (paddr == ADDR_VOLTAGE_REFERENCE_CONTROL) begin
        if (pwrite) begin
          next_state.voltage_reference_control =
            (state.voltage_reference_control & ~(wmask & VR_WRITE_MASK))
            | (pwdata[15:0] & wmask & VR_WRITE_MASK);
        end else begin
          next_state.prdata = {16'h0000, state.voltage_reference_control};
        end
      end else if (paddr == ADDR_CMP_RESULT) begin
        if (pwrite) begin
          next_state.pslverr = 1'b1;
        end else begin
          next_state.prdata = {30'h0000_0000, cmp2_result, cmp1_result};
        end
      end else begin
        next_state.pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.comparator_control        <= CC_RESET;
      state.voltage_reference_control <= VR_RESET;
      state.prdata                    <= RDATA_ZERO;
      state.pready                    <= 1'b0;
      state.pslverr                   <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign prdata  = state.prdata;
  assign pready  = state.pready;
  assign pslverr = state.pslverr;

  assign cmp1_positive_select  = state.comparator_control[CC_CMP1_POS];
  assign cmp1_negative_select  = state.comparator_control[CC_CMP1_NEG];
  assign cmp2_positive_select  = state.comparator_control[CC_CMP2_POS];
  assign cmp2_negative_select  = state.comparator_control[CC_CMP2_NEG];
  assign cmp1_inv_q            = state.comparator_control[CC_CMP1_INV];
  assign cmp2_inv_q            = state.comparator_control[CC_CMP2_INV];
  assign ref_power_enable      = state.voltage_reference_control[VR_POWER];
  assign ref_pin_output_enable = state.voltage_reference_control[VR_PIN_OE];
  assign ref_source_select     = state.voltage_reference_control[VR_SOURCE];
  assign ref_range_select      = ladder_range;
  assign ref_level_code        = ladder_tap;

  // ************************************************************
  // comparator result paths
  // ************************************************************
  cmp_out_path u_cmp1 (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (cmp1_raw),
    .invert  (cmp1_inv_q),
    .result  (cmp1_result)
  );

  cmp_out_path u_cmp2 (
    .pclk    (pclk),
    .presetn (presetn),
    .raw_in  (cmp2_raw),
    .invert  (cmp2_inv_q),
    .result  (cmp2_result)
  );

  // ************************************************************
  // reference ladder
  // ************************************************************
  ref_ladder_ctrl u_ladder (
    .pclk      (pclk),
    .presetn   (presetn),
    .power     (state.voltage_reference_control[VR_POWER]),
    .range_sel (state.voltage_reference_control[VR_RANGE]),
    .level     (state.voltage_reference_control[VR_LEVEL_LSB +: VR_LEVEL_W]),
    .tap_code  (ladder_tap),
    .range_out (ladder_range)
  );

  // ************************************************************
  // check helpers
  // ************************************************************
  logic       cc_write;
  logic       vr_write;
  logic [3:0] ref_level_bits;

  assign cc_write       = access && pwrite && paddr == ADDR_COMPARATOR_CONTROL;
  assign vr_write       = access && pwrite && paddr == ADDR_VOLTAGE_REFERENCE_CONTROL;
  assign ref_level_bits = state.voltage_reference_control[VR_LEVEL_LSB +: VR_LEVEL_W];

  // ************************************************************
  // checks
  // ************************************************************
  // result flops sit in reset on the edge before release, so that edge is skipped
  a_cmp2_invert: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |->
      cmp2_result == ($past(cmp2_raw) ^ $past(state.comparator_control[CC_CMP2_INV])))
    else $error("comparator two inversion wrong");
  a_cmp1_invert: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |->
      cmp1_result == ($past(cmp1_raw) ^ $past(state.comparator_control[CC_CMP1_INV])))
    else $error("comparator one inversion wrong");
  a_cc_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == ADDR_COMPARATOR_CONTROL && pstrb[0])
    |=> cmp2_negative_select == $past(pwdata[CC_CMP2_NEG]) && pready)
    else $error("comparator control write lost");
  a_cmp2_pos_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(access && pwrite) |=> $stable(cmp2_positive_select))
    else $error("comparator two positive select moved");
  a_cmp1_neg_map: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == ADDR_COMPARATOR_CONTROL && pstrb[0])
    |=> cmp1_negative_select == $past(pwdata[CC_CMP1_NEG]))
    else $error("comparator one negative select wrong");
  a_cmp1_pos_map: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == ADDR_COMPARATOR_CONTROL && pstrb[0])
    |=> cmp1_positive_select == $past(pwdata[CC_CMP1_POS]))
    else $error("comparator one positive select wrong");
  a_range_follow: assert property (@(posedge pclk) disable iff (!presetn)
    ref_range_select == $past(state.voltage_reference_control[VR_RANGE]
                              & state.voltage_reference_control[VR_POWER]))
    else $error("reference range wrong");
  a_source_map: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == ADDR_VOLTAGE_REFERENCE_CONTROL && pstrb[0])
    |=> ref_source_select == $past(pwdata[VR_SOURCE]))
    else $error("reference source wrong");
  a_level_tap: assert property (@(posedge pclk) disable iff (!presetn)
    ref_power_enable [*2] |-> ref_level_code == $past(ref_level_bits))
    else $error("ladder tap wrong");
  a_power_map: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && paddr == ADDR_VOLTAGE_REFERENCE_CONTROL && pstrb[0])
    |=> ref_power_enable == $past(pwdata[VR_POWER])
        && ref_pin_output_enable == $past(pwdata[VR_PIN_OE]))
    else $error("reference power or pin enable wrong");

  // ************************************************************
  // bus checks
  // ************************************************************
  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready stood longer than one cycle");

  a_ready_answer: assert property (@(posedge pclk) disable iff (!presetn)
    access |=> pready)
    else $error("access not answered");

  a_ready_cause: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> $past(access))
    else $error("ready without an access");

  a_error_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("error without ready");

  a_rdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready |-> prdata == RDATA_ZERO)
    else $error("read data not zero while idle");

  a_write_rdata: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite |=> prdata == RDATA_ZERO)
    else $error("read data not zero on write");

  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
    access && paddr != ADDR_COMPARATOR_CONTROL && paddr != ADDR_VOLTAGE_REFERENCE_CONTROL
    && paddr != ADDR_CMP_RESULT |=> pslverr)
    else $error("unmapped access without error");

  a_result_write_error: assert property (@(posedge pclk) disable iff (!presetn)
    access && pwrite && paddr == ADDR_CMP_RESULT |=> pslverr)
    else $error("result write without error");

  a_mapped_no_error: assert property (@(posedge pclk) disable iff (!presetn)
    access && (paddr == ADDR_COMPARATOR_CONTROL || paddr == ADDR_VOLTAGE_REFERENCE_CONTROL)
    |=> !pslverr)
    else $error("mapped access flagged as error");

  a_cc_read_data: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && paddr == ADDR_COMPARATOR_CONTROL
    |=> prdata == {16'h0000, $past(state.comparator_control)})
    else $error("comparator control read wrong");

  a_vr_read_data: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && paddr == ADDR_VOLTAGE_REFERENCE_CONTROL
    |=> prdata == {16'h0000, $past(state.voltage_reference_control)})
    else $error("reference control read wrong");

  a_result_read: assert property (@(posedge pclk) disable iff (!presetn)
    access && !pwrite && paddr == ADDR_CMP_RESULT
    |=> prdata == {30'h0000_0000, $past(cmp2_result), $past(cmp1_result)})
    else $error("comparator result read wrong");

  // ************************************************************
  // register checks
  // ************************************************************
  a_cc_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !cc_write |=> $stable(state.comparator_control))
    else $error("comparator control moved without a write");

  a_vr_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !vr_write |=> $stable(state.voltage_reference_control))
    else $error("reference control moved without a write");

  a_cc_strobe_guard: assert property (@(posedge pclk) disable iff (!presetn)
    cc_write && !pstrb[0] |=> $stable(state.comparator_control))
    else $error("comparator control written without low strobe");

  a_vr_strobe_guard: assert property (@(posedge pclk) disable iff (!presetn)
    vr_write && !pstrb[0] |=> $stable(state.voltage_reference_control))
    else $error("reference control written without low strobe");

  // unused bits must stay clear so software reads them as zero
  a_cc_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (state.comparator_control & ~CC_WRITE_MASK) == 16'h0000)
    else $error("comparator control unused bits set");

  a_vr_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (state.voltage_reference_control & ~VR_WRITE_MASK) == 16'h0000)
    else $error("reference control unused bits set");

  a_cmp2_pos_map: assert property (@(posedge pclk) disable iff (!presetn)
    cc_write && pstrb[0]
    |=> cmp2_positive_select == $past(pwdata[CC_CMP2_POS]))
    else $error("comparator two positive select wrong");

  a_cmp2_inv_map: assert property (@(posedge pclk) disable iff (!presetn)
    cc_write && pstrb[0]
    |=> cmp2_inv_q == $past(pwdata[CC_CMP2_INV]))
    else $error("comparator two invert bit wrong");

  a_cmp1_inv_map: assert property (@(posedge pclk) disable iff (!presetn)
    cc_write && pstrb[0]
    |=> cmp1_inv_q == $past(pwdata[CC_CMP1_INV]))
    else $error("comparator one invert bit wrong");

  // ************************************************************
  // ladder checks
  // ************************************************************
  // ladder outputs lag the register by one more edge
  a_range_map: assert property (@(posedge pclk) disable iff (!presetn)
    vr_write && pstrb[0] |=> ##1
    ref_range_select == ($past(pwdata[VR_RANGE], 2) && $past(pwdata[VR_POWER], 2)))
    else $error("written range not on ladder");

  a_level_map: assert property (@(posedge pclk) disable iff (!presetn)
    vr_write && pstrb[0] |=> ##1
    ref_level_code == ($past(pwdata[VR_POWER], 2)
                       ? $past(pwdata[VR_LEVEL_LSB +: VR_LEVEL_W], 2) : 4'h0))
    else $error("written level not on ladder");

  a_unpowered_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !ref_power_enable |=> ref_level_code == 4'h0 && !ref_range_select)
    else $error("ladder active while unpowered");

  a_range_power: assert property (@(posedge pclk) disable iff (!presetn)
    ref_range_select |-> $past(ref_power_enable))
    else $error("range selected without power");

  a_source_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !vr_write |=> $stable(ref_source_select))
    else $error("source select moved without a write");
endmodule

// File: comparator_reference_control_test.sv
`timescale 1ns/10ps
module comparator_reference_control_test;
  import cmpref_pkg::*;
  // ************
  // bench state
  // ************
  logic        pclk    = 1'b0;
  logic        presetn = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h00000000;
  logic [3:0]  pstrb   = 4'hF;
  logic        cmp1_raw = 1'b0;
  logic        cmp2_raw = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr;
  logic        c1p, c1n, c2p, c2n, c1r, c2r, rpw, roe, rrg, rsrc;
  logic [3:0]  rlev;
  logic [33:0] exp_q[$];
  int          error_cnt   = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  logic [31:0] lfsr = 32'h0000ADCD;
  logic [31:0] v;
  logic [33:0] head;

  always #5 pclk = ~pclk;

  comparator_reference_control dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmp1_raw(cmp1_raw), .cmp2_raw(cmp2_raw),
    .cmp1_positive_select(c1p), .cmp1_negative_select(c1n),
    .cmp2_positive_select(c2p), .cmp2_negative_select(c2n),
    .cmp1_result(c1r), .cmp2_result(c2r), .ref_power_enable(rpw),
    .ref_pin_output_enable(roe), .ref_range_select(rrg),
    .ref_source_select(rsrc), .ref_level_code(rlev));

  // ************
  // helpers
  // ************
  function automatic logic [31:0] lfsr_next();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  task automatic check(input string what, input logic [32:0] exp, input logic [32:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // note is {is_read, slverr, rdata}; held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s, input logic [33:0] note);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    exp_q.push_back(note);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ************
  // response monitor
  // ************
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      final_report();
    end else if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected response", 33'h0, 33'h1_FFFF_FFFF);
      end else begin
        head = exp_q.pop_front();
        if (head[33]) check("read", head[32:0], {pslverr, prdata});
        else check("write slverr", {head[32], 32'h0}, {pslverr, 32'h0});
      end
    end
  end

  // ************
  // scenarios
  // ************
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check("reset outs", 33'h0, {c1p, c1n, c2p, c2n, c1r, c2r, rpw, roe, rrg, rsrc, rlev});
    apb(1'b0, ADDR_VOLTAGE_REFERENCE_CONTROL, 32'h0, 4'hF, {2'b10, 16'h0, VR_RESET});
    apb(1'b0, ADDR_COMPARATOR_CONTROL, 32'h0, 4'hF, {2'b10, 16'h0, CC_RESET});
    // walking ones first, then random words with junk in ignored bits
    for (int i = 0; i < 24; i++) begin
      v = (i < 6) ? (32'h1 << i) : lfsr_next();
      cmp1_raw <= v[8];
      cmp2_raw <= v[9];
      apb(1'b1, ADDR_COMPARATOR_CONTROL, v, 4'hF, 34'h0);
      apb(1'b0, ADDR_COMPARATOR_CONTROL, 32'h0, 4'hF, {2'b10, 16'h0, v[15:0] & CC_WRITE_MASK});
      #1;
      check("selects", {29'h0, v[3:0]}, {29'h0, c2n, c2p, c1n, c1p});
      check("results", {31'h0, v[9] ^ v[5], v[8] ^ v[4]}, {31'h0, c2r, c1r});
      apb(1'b0, ADDR_CMP_RESULT, 32'h0, 4'hF, {2'b10, 30'h0, v[9] ^ v[5], v[8] ^ v[4]});
    end
    // low strobe off: the comparator settings must not move
    apb(1'b1, ADDR_COMPARATOR_CONTROL, ~v, 4'hE, 34'h0);
    apb(1'b0, ADDR_COMPARATOR_CONTROL, 32'h0, 4'hF, {2'b10, 16'h0, v[15:0] & CC_WRITE_MASK});
    // every level in both ranges while powered, then random incl. unpowered
    for (int i = 0; i < 40; i++) begin
      v = lfsr_next();
      if (i < 32) v[7:0] = {1'b1, v[6], i[4], v[4], i[3:0]};
      apb(1'b1, ADDR_VOLTAGE_REFERENCE_CONTROL, v, 4'hF, 34'h0);
      apb(1'b0, ADDR_VOLTAGE_REFERENCE_CONTROL, 32'h0, 4'hF, {2'b10, 16'h0, v[15:0] & VR_WRITE_MASK});
      @(posedge pclk);
      #1;
      check("power oe source", {30'h0, v[7], v[6], v[4]}, {30'h0, rpw, roe, rsrc});
      check("range level", {28'h0, v[7] ? {v[5], v[3:0]} : 5'h0}, {28'h0, rrg, rlev});
    end
    // upper byte strobe only: the low byte must keep its value
    apb(1'b1, ADDR_VOLTAGE_REFERENCE_CONTROL, 32'h0000FF00, 4'h2, 34'h0);
    apb(1'b0, ADDR_VOLTAGE_REFERENCE_CONTROL, 32'h0, 4'hF, {2'b10, 24'h0, v[7:0]});
    apb(1'b1, ADDR_CMP_RESULT, 32'h3, 4'hF, {2'b01, 32'h0});
    apb(1'b0, 12'h00C, 32'h0, 4'hF, {2'b11, 32'h0});
    apb(1'b1, 12'hFFC, 32'h1, 4'hF, {2'b01, 32'h0});
    // second reset in mid-run clears everything again
    presetn  <= 1'b0;
    cmp1_raw <= 1'b0;
    cmp2_raw <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    check("mid reset outs", 33'h0, {c1p, c1n, c2p, c2n, c1r, c2r, rpw, roe, rrg, rsrc, rlev});
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    check("mid release outs", 33'h0, {c1p, c1n, c2p, c2n, c1r, c2r, rpw, roe, rrg, rsrc, rlev});
    apb(1'b0, ADDR_VOLTAGE_REFERENCE_CONTROL, 32'h0, 4'hF, {2'b10, 32'h0});
    apb(1'b0, ADDR_COMPARATOR_CONTROL, 32'h0, 4'hF, {2'b10, 16'h0, CC_RESET});
    repeat (2) @(posedge pclk);
    check("queue drained", 33'h0, {1'b0, exp_q.size()});
    final_report();
  end
endmodule

// File: ref_ladder_ctrl.sv
`timescale 1ns/10ps
// reference ladder tap and control, ladder idle while unpowered
module ref_ladder_ctrl (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // settings
  input  wire logic       power,
  input  wire logic       range_sel,
  input  wire logic [3:0] level,
  // ladder drive
  output logic [3:0]      tap_code,
  output logic            range_out
);
  typedef struct packed {
    logic [3:0] tap_code;
    logic       range_out;
  } ladder_state_t;

  ladder_state_t state;
  ladder_state_t next_state;

  always_comb begin
    next_state = state;
    // tap held at zero while powered down so the ladder draws no switching current
    if (power) begin
      next_state.tap_code  = level;
      next_state.range_out = range_sel;
    end else begin
      next_state.tap_code  = 4'h0;
      next_state.range_out = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tap_code  = state.tap_code;
  assign range_out = state.range_out;
endmodule
